// file: icwdt_map.svh
// icwdt_map.svh: counter width, load value and flag reset values of the watchdog.
// assumes inclusion by bare name from the package and design files.
`ifndef ICWDT_MAP_SVH
`define ICWDT_MAP_SVH

`define ICWDT_CNT_W 16
`define ICWDT_CNT_INIT 16'hffff
`define ICWDT_CNT_ZERO 16'h0000
`define ICWDT_CNT_ONE 16'h0001
`define ICWDT_ENABLE_RST 1'b1
`define ICWDT_FLAG_RST 1'b0
`define ICWDT_PIN_IDLE 1'b1

`endif

// file: icwdt_pkg.sv
// icwdt_pkg: types shared by the watchdog design files.
// assumes icwdt_map.svh is reachable on the include path.
`include "icwdt_map.svh"

package icwdt_pkg;

  // tracks whether the last executed instruction was the disable instruction
  typedef enum logic [1:0]
  {
    ICWDT_SEQ_IDLE = 2'b01,
    ICWDT_SEQ_DIS = 2'b10
  } icwdt_seq_t;

  typedef logic [`ICWDT_CNT_W-1:0] icwdt_count_t;

endpackage

// file: icwdt_cnt_if.sv
// icwdt_cnt_if: link between watchdog control and its down-counter.
// assumes both ends run on the same clock.
`timescale 1ns/10ps

interface icwdt_cnt_if;
  import icwdt_pkg::*;
  logic load;
  logic dec;
  logic underflow;
  icwdt_count_t count;

  modport ctrl (output load, output dec, input underflow, input count);
  modport cnt (input load, input dec, output underflow, output count);
endinterface

// file: icwdt_down_counter.sv
// icwdt_down_counter: 16-bit down-counter clocked by instruction-cycle pulses.
// assumes load and dec come from logic on the same clock; load has priority.
`timescale 1ns/10ps
`include "icwdt_map.svh"

module icwdt_down_counter
  import icwdt_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  icwdt_cnt_if.cnt port
);

  icwdt_count_t count_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // count value, wraps from zero to all ones on underflow
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count_ff <= `ICWDT_CNT_INIT;
    else if (port.load)
      count_ff <= `ICWDT_CNT_INIT;
    else if (port.dec)
      count_ff <= count_ff - `ICWDT_CNT_ONE; // zero wraps to all ones
  end

  // underflow: a count pulse while already at zero
  assign port.underflow = port.dec && !port.load && (count_ff == `ICWDT_CNT_ZERO);
  assign port.count = count_ff;

endmodule // icwdt_down_counter

// file: icwdt_watchdog.sv
// icwdt_watchdog: program run-away watchdog with refresh skip and open-drain reset.
// assumes instruction strobes and count ticks come from the core on the same clock;
// the reset pin level arrives from outside and is synchronised here.
`timescale 1ns/10ps
`include "icwdt_map.svh"

// Behaviour
// R01: after reset the counter starts at all ones, one decrement per instruction cycle.
// R02: a count pulse at zero is an underflow and sets the first flag.
// R03: underflow with first flag set sets second flag and watchdog reset.
// R04: watchdog reset turns on the reset pin driver, pulling it low.
// R05: software must refresh within 65534 machine cycles while watchdog used.
// R06: enable flag set by system reset and back-up entry; enables reset function.
// R07: disable immediately followed by refresh clears the enable flag.
// R08: disable alone leaves the watchdog running and enable unchanged.
// R09: refresh with first flag set clears it and skips the next instruction.
// R10: refresh with first flag clear does not skip.
// R11: the refresh skip still works while the reset function is disabled.
// R12: back-up mode entry reinitialises first flag and counter.
// R13: software repeats the disable pair after each return from back-up.
// R14: software should refresh just before entering back-up mode.
// R15: the resulting system reset reloads counter and clears both flags.
module icwdt_watchdog
  import icwdt_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic instr_tick,
  input wire logic instr_valid,
  input wire logic refresh_instruction,
  input wire logic disable_instruction,
  input wire logic ram_backup_entry,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic skip_next,
  output logic watchdog_enable_flag,
  output logic first_underflow_flag,
  output logic second_underflow_flag,
  output icwdt_count_t watchdog_down_counter
);

  logic pin_meta_ff;
  logic pin_sync_ff;
  logic sys_reset_seen;
  logic reinit;
  logic refresh_exec;
  logic enable_ff;
  logic flag1_ff;
  logic flag2_ff;
  logic skip_ff;
  logic nxt_skip;
  icwdt_seq_t seq_ff;
  icwdt_seq_t nxt_seq;

  icwdt_cnt_if cnt_link ();

  ////////////////////////////////////////////////////////////////////////////////
  // reset pin synchroniser; only the second stage is looked at
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_ff <= `ICWDT_PIN_IDLE;
      pin_sync_ff <= `ICWDT_PIN_IDLE;
    end
    else
    begin
      pin_meta_ff <= reset_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // a low pin, from any driver, is a system reset of the watchdog
  assign sys_reset_seen = !pin_sync_ff;
  assign reinit = sys_reset_seen || ram_backup_entry;
  assign refresh_exec = instr_valid && refresh_instruction;

  ////////////////////////////////////////////////////////////////////////////////
  // counter: reloaded by system reset and back-up entry, else counts ticks
  assign cnt_link.load = reinit; // see R12, see R15
  assign cnt_link.dec = instr_tick; // see R01

  icwdt_down_counter u_counter
  (
    .clock (clock),
    .rst_n (rst_n),
    .port (cnt_link.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // instruction pair tracker: remembers that the previous instruction was disable
  always_comb
  begin
    nxt_seq = seq_ff;
    case (seq_ff)
      ICWDT_SEQ_IDLE:
        if (instr_valid && disable_instruction)
          nxt_seq = ICWDT_SEQ_DIS;
      ICWDT_SEQ_DIS:
        if (instr_valid && !disable_instruction)
          nxt_seq = ICWDT_SEQ_IDLE; // any other instruction breaks the pair, see R08
      default:
        nxt_seq = ICWDT_SEQ_IDLE;
    endcase
    if (reinit)
      nxt_seq = ICWDT_SEQ_IDLE;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      seq_ff <= ICWDT_SEQ_IDLE;
    else
      seq_ff <= nxt_seq;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // enable flag: set by resets, cleared only by disable then refresh
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      enable_ff <= `ICWDT_ENABLE_RST;
    else if (reinit)
      enable_ff <= `ICWDT_ENABLE_RST; // see R06
    else if (seq_ff == ICWDT_SEQ_DIS && refresh_exec)
      enable_ff <= 1'b0; // see R07
  end

  ////////////////////////////////////////////////////////////////////////////////
  // first flag: underflow sets it and wins over a refresh in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flag1_ff <= `ICWDT_FLAG_RST;
    else if (reinit)
      flag1_ff <= `ICWDT_FLAG_RST; // see R12, see R15
    else if (cnt_link.underflow)
      flag1_ff <= 1'b1; // see R02
    else if (refresh_exec)
      flag1_ff <= 1'b0; // see R09
  end

  ////////////////////////////////////////////////////////////////////////////////
  // second flag: a second underflow while enabled raises the watchdog reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flag2_ff <= `ICWDT_FLAG_RST;
    else if (sys_reset_seen)
      flag2_ff <= `ICWDT_FLAG_RST; // see R15
    else if (cnt_link.underflow && flag1_ff && enable_ff)
      flag2_ff <= 1'b1; // see R03
  end

  ////////////////////////////////////////////////////////////////////////////////
  // skip request: independent of the enable flag, so it works when disabled
  assign nxt_skip = refresh_exec && flag1_ff && !reinit; // see R09, see R10, see R11

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      skip_ff <= 1'b0;
    else
      skip_ff <= nxt_skip;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // open-drain reset pin: drives low only; the pin's low level clears flag2,
  // so the pulse lasts only until the synchroniser sees it (a few cycles)
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = flag2_ff; // see R04
  assign skip_next = skip_ff;
  assign watchdog_enable_flag = enable_ff;
  assign first_underflow_flag = flag1_ff;
  assign second_underflow_flag = flag2_ff;
  assign watchdog_down_counter = cnt_link.count;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_count_load_ones: assert property ( // see R01
    reinit |=> watchdog_down_counter == `ICWDT_CNT_INIT)
    else $error("counter not loaded with all ones");

  a_count_decrements: assert property ( // see R01
    instr_tick && !reinit && watchdog_down_counter != `ICWDT_CNT_ZERO
    |=> watchdog_down_counter == $past(watchdog_down_counter) - `ICWDT_CNT_ONE)
    else $error("counter did not decrement by one");

  a_underflow_flag_one: assert property ( // see R02
    instr_tick && !reinit && watchdog_down_counter == `ICWDT_CNT_ZERO
    |=> first_underflow_flag && watchdog_down_counter == `ICWDT_CNT_INIT)
    else $error("underflow did not set first flag");

  a_second_underflow_rst: assert property ( // see R03
    instr_tick && !reinit && watchdog_down_counter == `ICWDT_CNT_ZERO
    && first_underflow_flag && watchdog_enable_flag
    |=> second_underflow_flag)
    else $error("second underflow did not raise watchdog reset");

  a_pin_driven_low: assert property ( // see R04
    $rose(second_underflow_flag) |-> reset_pin_oe && !reset_pin_out
    throughout (##[0:2] sys_reset_seen))
    else $error("reset pin not pulled low by watchdog reset");

  a_enable_after_reinit: assert property ( // see R06
    reinit |=> watchdog_enable_flag)
    else $error("enable flag not set after reset or back-up");

  // one idle cycle between instructions, the spacing the core keeps
  a_pair_disables: assert property ( // see R07
    instr_valid && disable_instruction && !reinit
    ##1 (!instr_valid && !reinit)
    ##1 (refresh_exec && !reinit) |=> !watchdog_enable_flag)
    else $error("disable pair did not clear enable flag");

  // a broken pair must not let the later refresh clear the enable flag
  a_lone_disable_keeps: assert property ( // see R08
    instr_valid && disable_instruction && !reinit
    ##1 (!instr_valid && !reinit)
    ##1 (instr_valid && !refresh_instruction && !disable_instruction && !reinit)
    ##1 (!instr_valid && !reinit)
    ##1 (refresh_exec && !reinit)
    |=> watchdog_enable_flag == $past(watchdog_enable_flag, 5))
    else $error("lone disable changed enable flag");

  a_skip_on_flag: assert property ( // see R09, see R11
    refresh_exec && first_underflow_flag && !reinit
    |=> skip_next ##1 !skip_next)
    else $error("refresh with flag set did not skip once");

  a_no_skip_clear: assert property ( // see R10
    refresh_exec && !first_underflow_flag |=> !skip_next)
    else $error("refresh with flag clear skipped");

  a_backup_reinit: assert property ( // see R12
    ram_backup_entry |=> !first_underflow_flag
    && watchdog_down_counter == `ICWDT_CNT_INIT)
    else $error("back-up entry did not reinitialise");

  a_sysreset_clears: assert property ( // see R15
    sys_reset_seen |=> !first_underflow_flag && !second_underflow_flag)
    else $error("system reset did not clear flags");

  c_underflow: cover property (first_underflow_flag && instr_tick);
  c_skip: cover property (skip_next);
  c_disabled: cover property ($fell(watchdog_enable_flag));
  c_watchdog_reset: cover property ($rose(second_underflow_flag));

endmodule // icwdt_watchdog

// file: icwdt_core_model.sv
// icwdt_core_model: behavioural core issuing instructions and count pulses.
// assumes one shared clock and a pull-up on the reset pin wire.
`timescale 1ns/10ps

module icwdt_core_model
(
  input wire logic clock,
  input wire logic reset_pin_oe,
  output logic instr_tick,
  output logic instr_valid,
  output logic refresh_instruction,
  output logic disable_instruction,
  output logic ram_backup_entry,
  output logic reset_pin_in
);
  // pull-up holds the pin high unless the watchdog driver is on
  assign reset_pin_in = reset_pin_oe ? 1'b0 : 1'b1;
  // idle state at time zero
  initial
  begin
    instr_tick = 1'b0;
    instr_valid = 1'b0;
    refresh_instruction = 1'b0;
    disable_instruction = 1'b0;
    ram_backup_entry = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // n pulses back to back; refresh does not reload the counter, so enough pulses run the count out either way
  task ticks(input int n);
    repeat (n)
    begin
      @(posedge clock);
      instr_tick <= 1'b1;
    end
    @(posedge clock);
    instr_tick <= 1'b0;
  endtask
  // one instruction; qualifiers flip afterwards so stale values never help
  task exec(input logic r, input logic d, input logic t);
    @(posedge clock);
    instr_valid <= 1'b1;
    refresh_instruction <= r;
    disable_instruction <= d;
    instr_tick <= t;
    @(posedge clock);
    instr_valid <= 1'b0;
    refresh_instruction <= ~r;
    disable_instruction <= ~d;
    instr_tick <= 1'b0;
  endtask
  // single-cycle entry pulse into back-up mode
  task backup();
    @(posedge clock);
    ram_backup_entry <= 1'b1;
    @(posedge clock);
    ram_backup_entry <= 1'b0;
  endtask
endmodule // icwdt_core_model

// file: instruction_clock_watchdog_tb.sv
// instruction_clock_watchdog_tb: self-checking bench for the watchdog top.
// assumes the core model drives all instruction-side inputs.
`timescale 1ns/10ps

module instruction_clock_watchdog_tb;
  import icwdt_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic tick, valid, rfr, dis, bkp, pin_in, pin_out, oe, skip, en, f1, f2;
  icwdt_count_t cnt;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #25 clock = ~clock;

  icwdt_core_model core (.clock(clock), .reset_pin_oe(oe), .instr_tick(tick),
    .instr_valid(valid), .refresh_instruction(rfr), .disable_instruction(dis),
    .ram_backup_entry(bkp), .reset_pin_in(pin_in));

  icwdt_watchdog dut (.clock(clock), .rst_n(rst_n), .instr_tick(tick), .instr_valid(valid),
    .refresh_instruction(rfr), .disable_instruction(dis), .ram_backup_entry(bkp),
    .reset_pin_in(pin_in), .reset_pin_out(pin_out), .reset_pin_oe(oe), .skip_next(skip),
    .watchdog_enable_flag(en), .first_underflow_flag(f1), .second_underflow_flag(f2),
    .watchdog_down_counter(cnt));

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tally_and_finish();
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // two underflows need about 131k cycles, so the ceiling sits just above
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 140000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task s_basic();
    @(negedge clock);
    chk(cnt, 16'hffff);
    chk(en, 1'b1);
    chk({f1, f2, oe}, 3'h0);
    core.ticks(3);
    @(negedge clock);
    chk(cnt, 16'hfffc);
  endtask

  // refresh with flag clear, then a lone disable broken by another instruction
  task s_lone();
    core.exec(1'b1, 1'b0, 1'b0);
    @(negedge clock);
    chk(skip, 1'b0);
    core.exec(1'b0, 1'b1, 1'b0);
    core.exec(1'b0, 1'b0, 1'b0);
    core.exec(1'b1, 1'b0, 1'b0); // refresh after the broken pair must not disable
    @(negedge clock);
    chk(en, 1'b1);
  endtask

  // pair with an idle gap, then back-up entry re-arms enable, counter and first flag
  task s_pair();
    core.exec(1'b0, 1'b1, 1'b0);
    core.exec(1'b1, 1'b0, 1'b0);
    @(negedge clock);
    chk(en, 1'b0);
    core.exec(1'b1, 1'b0, 1'b0);
    core.backup();
    @(negedge clock);
    chk(en, 1'b1);
    chk(cnt, 16'hffff);
    chk(f1, 1'b0);
    // program that does not want the watchdog repeats the pair after back-up
    core.exec(1'b0, 1'b1, 1'b0);
    core.exec(1'b1, 1'b0, 1'b0);
    @(negedge clock);
    chk(en, 1'b0);
    // re-arm for the run-away scenario
    core.backup();
    @(negedge clock);
    chk(en, 1'b1);
  endtask

  // no refresh: first underflow, then second underflow with a late refresh
  task s_runaway();
    core.ticks(65536);
    @(negedge clock);
    chk({f1, f2}, 2'h2);
    chk(cnt, 16'hffff);
    core.ticks(65535);
    core.exec(1'b1, 1'b0, 1'b1);
    @(negedge clock);
    chk(skip, 1'b1);
    chk(f2, 1'b1);
    chk({oe, pin_out, pin_in}, 3'h4);
    for (int i = 0; i < 10 && oe === 1'b1; i++)
      @(negedge clock);
    chk({oe, f1, f2, en}, 4'h1);
    chk(cnt, 16'hffff);
  endtask

  initial
  begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    s_basic();
    s_lone();
    s_pair();
    s_runaway();
    tally_and_finish();
  end
endmodule // instruction_clock_watchdog_tb
